/* File: logic/lamp_cfg.svh */
// Constants for the lamp chop, configuration and status logic
`ifndef LAMP_CFG_SVH
`define LAMP_CFG_SVH

// Configuration byte layout
`define CFG_ROUTE_BIT    7
`define CFG_RUN_BIT      6
`define CFG_STBY_BIT     5
`define CFG_CODE_MSB     4
`define CFG_RESET        7'h70

// Status byte layout
`define STAT_OK_BIT      7
`define STAT_FILL        2'h3
`define STAT_OK_RESET    1'h1

// Chop timing, in switching clock cycles
`define CHOP_PERIOD      1024
`define CHOP_STEP        11'h021
`define CHOP_MIN_CODE    5'h03
`define CHOP_FULL_CODE   5'h1f
`define CHOP_FULL_THR    11'h400

// Serial slave address (arbitrary value)
`define SLAVE_ADDR       7'h2c

`endif

/* File: logic/lamp_pkg.sv */
// Types shared by the lamp chop and status logic
package lamp_pkg;

  // Serial slave states, one-hot
  typedef enum logic [6:0] {
    SER_IDLE   = 7'h01,
    SER_ADDR   = 7'h02,
    SER_AACK   = 7'h04,
    SER_WDATA  = 7'h08,
    SER_WACK   = 7'h10,
    SER_RDATA  = 7'h20,
    SER_RACK   = 7'h40
  } ser_state_t;

endpackage

/* File: logic/pin_sync.sv */
// Three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int          WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] meta_reg;   // First stage, read only by stage two
  logic [WIDTH-1:0] s2_reg;     // Second stage
  logic [WIDTH-1:0] s3_reg;     // Third stage
  logic [WIDTH-1:0] out_reg;    // Filtered level
  logic [WIDTH-1:0] out_next;

  // Take a new level only where stages two and three agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : out_reg[i];
    end
  end

  // Register chain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= INIT;
      s2_reg   <= INIT;
      s3_reg   <= INIT;
      out_reg  <= INIT;
    end else begin
      meta_reg <= pin_in;
      s2_reg   <= meta_reg;
      s3_reg   <= s2_reg;
      out_reg  <= out_next;
    end
  end

  assign pin_out = out_reg;

endmodule
`default_nettype wire

/* File: logic/chop_pwm.sv */
// Free-running chop counter and duty compare
`timescale 1ns/1ps
`default_nettype none
`include "lamp_cfg.svh"
module chop_pwm #(
  parameter int PERIOD = `CHOP_PERIOD
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [4:0] code,
  output logic            lamp_on
);

  localparam int CW = $clog2(PERIOD);

  // The compare below assumes a power-of-two period of 1024
  if (PERIOD != `CHOP_PERIOD) begin : g_bad_period
    $error("chop_pwm: PERIOD must be 1024");
  end

  logic [CW-1:0] cnt_reg;     // Position in the chop period
  logic [CW-1:0] cnt_next;
  logic          on_reg;      // Registered lamp-on level
  logic          on_next;

  // On-time threshold from the brightness code
  function automatic logic [10:0] duty_thr(input logic [4:0] c);
    if (c == 5'h00) begin
      duty_thr = 11'h000;
    end else if (c == `CHOP_FULL_CODE) begin
      duty_thr = `CHOP_FULL_THR;
    end else if (c <= `CHOP_MIN_CODE) begin
      duty_thr = 11'(`CHOP_MIN_CODE * `CHOP_STEP);
    end else begin
      duty_thr = 11'(c * `CHOP_STEP);
    end
  endfunction

  // Counter wraps by itself; lamp on while below threshold
  always_comb begin
    cnt_next = cnt_reg + 1'b1;
    on_next  = ({1'b0, cnt_next} < duty_thr(code));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      on_reg  <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      on_reg  <= on_next;
    end
  end

  assign lamp_on = on_reg;

endmodule
`default_nettype wire

/* File: logic/lamp_chop_duty_and_status.sv */
// Lamp chop, configuration banks, status readback and serial slave
//
// What this block does
// - Status low five bits show selected code
// - Status byte answered on serial read-byte
// - Two 7-bit configuration registers, pin selects
// - Shutdown from selected run bit; serial stays alive
// - Writing run bit one leaves shutdown
// - Chop mode only when strap tied high
// - Chop output low off, high on
// - Off time: switch off, compensation high-Z
// - Chop period is 1024 switching clocks
// - Duty set by code, about 3% steps
// - Full-scale code gives 100% duty
// - Codes one to three give 9% minimum
// - Code zero gives 0% duty
// - Byte MSB routes data to register 1
// - Status bits 6 and 5 read one
// - Open-lamp flag latched low, reset by shutdown
`timescale 1ns/1ps
`default_nettype none
`include "lamp_cfg.svh"
module lamp_chop_duty_and_status #(
  parameter logic [6:0] SLAVE_ADDR = `SLAVE_ADDR,  // Arbitrary default
  parameter int         PERIOD     = `CHOP_PERIOD
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       config_bank_select,
  input  wire logic       chop_mode_strap,
  input  wire logic       open_lamp_trip,
  output logic            chop_out,
  output logic            switch_enable,
  output logic            compensation_node_hiz,
  output logic            shutdown,
  output logic            standby,
  output logic [7:0]      status_byte
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic scl_s;          // Filtered serial clock
  logic sda_s;          // Filtered serial data
  logic bank_s;         // Filtered bank select
  logic strap_s;        // Filtered chop strap
  logic trip_s;         // Filtered open-lamp comparator

  // Bus lines idle high, so start them high to avoid a false start
  pin_sync #(
    .WIDTH (2),
    .INIT  (2'h3)
  ) u_sync_bus (
    .clk     (clk),
    .rst     (rst),
    .pin_in  ({scl_in, sda_in}),
    .pin_out ({scl_s, sda_s})
  );

  // Static-ish control pins
  pin_sync #(
    .WIDTH (3),
    .INIT  (3'h0)
  ) u_sync_ctl (
    .clk     (clk),
    .rst     (rst),
    .pin_in  ({config_bank_select, chop_mode_strap, open_lamp_trip}),
    .pin_out ({bank_s, strap_s, trip_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus edge and condition detection

  logic scl_d_reg;      // Last filtered clock
  logic sda_d_reg;      // Last filtered data
  logic scl_rise;       // Clock went high
  logic scl_fall;       // Clock went low
  logic bus_start;      // Data fell with clock high
  logic bus_stop;       // Data rose with clock high

  // Edges are taken from the filtered levels only
  always_comb begin
    scl_rise  = scl_s & ~scl_d_reg;
    scl_fall  = ~scl_s & scl_d_reg;
    bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    bus_stop  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  end

  // Delay stage for edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration banks and derived modes

  logic [6:0] cfg0_reg;         // Bank 0 configuration
  logic [6:0] cfg1_reg;         // Bank 1 configuration
  logic [6:0] cfg0_next;
  logic [6:0] cfg1_next;
  logic [6:0] cfg_sel;          // Bank chosen by the select pin
  logic       commit;           // Pending byte is a configuration write
  logic [7:0] pend_reg;         // Last received data byte

  // Select pin picks the live bank
  always_comb begin
    cfg_sel  = bank_s ? cfg1_reg : cfg0_reg;
    shutdown = ~cfg_sel[`CFG_RUN_BIT];
    standby  = ~cfg_sel[`CFG_STBY_BIT];
  end

  // Stored bytes land in the bank named by their top bit
  always_comb begin
    cfg0_next = cfg0_reg;
    cfg1_next = cfg1_reg;
    if (commit) begin
      if (pend_reg[`CFG_ROUTE_BIT]) begin
        cfg1_next = pend_reg[6:0];
      end else begin
        cfg0_next = pend_reg[6:0];
      end
    end
  end

  // Writes work in shutdown too, which is how software wakes it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg0_reg <= `CFG_RESET;
      cfg1_reg <= `CFG_RESET;
    end else begin
      cfg0_reg <= cfg0_next;
      cfg1_reg <= cfg1_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-lamp flag and status byte

  logic ok_reg;         // Open-lamp ok flag, low once tripped
  logic ok_next;

  // Shutdown or standby re-arms; they win over a trip in the same cycle
  always_comb begin
    ok_next = ok_reg;
    if (shutdown || standby) begin
      ok_next = 1'b1;
    end else if (trip_s) begin
      ok_next = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ok_reg <= `STAT_OK_RESET;
    end else begin
      ok_reg <= ok_next;
    end
  end

  logic [7:0] stat_next;        // Status as it stands now
  logic [7:0] stat_reg;         // Registered copy for the port

  // Flag, two fill bits, then the live brightness code
  always_comb begin
    stat_next = {ok_next, `STAT_FILL, cfg_sel[`CFG_CODE_MSB:0]};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_reg <= {`STAT_OK_RESET, `STAT_FILL, 5'(`CFG_RESET)};
    end else begin
      stat_reg <= stat_next;
    end
  end

  assign status_byte = stat_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Serial slave

  lamp_pkg::ser_state_t st_reg;     // Slave state
  lamp_pkg::ser_state_t st_next;
  logic [3:0] cnt_reg;              // Bits seen in the current byte
  logic [3:0] cnt_next;
  logic [7:0] sh_reg;               // Receive shift register
  logic [7:0] sh_next;
  logic [7:0] tx_reg;               // Transmit shift register
  logic [7:0] tx_next;
  logic       drv_reg;              // Pull data low
  logic       drv_next;
  logic       rw_reg;               // Read requested
  logic       rw_next;
  logic [7:0] pend_next;
  logic       pv_reg;               // Pending byte waits for stop
  logic       pv_next;

  // A write byte is only a configuration byte if a stop follows it;
  // a repeated start means it was the command of a read-byte and is dropped
  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    sh_next   = sh_reg;
    tx_next   = tx_reg;
    drv_next  = drv_reg;
    rw_next   = rw_reg;
    pend_next = pend_reg;
    pv_next   = pv_reg;
    commit    = 1'b0;
    if (bus_start) begin
      // Start or repeated start
      st_next  = lamp_pkg::SER_ADDR;
      cnt_next = 4'h0;
      drv_next = 1'b0;
      pv_next  = 1'b0;
    end else if (bus_stop) begin
      // Stop commits a send-byte
      commit   = pv_reg;
      pv_next  = 1'b0;
      st_next  = lamp_pkg::SER_IDLE;
      drv_next = 1'b0;
    end else begin
      case (st_reg)
        lamp_pkg::SER_IDLE: begin
          drv_next = 1'b0;
        end
        lamp_pkg::SER_ADDR: begin
          // Shift in address and direction
          if (scl_rise) begin
            sh_next  = {sh_reg[6:0], sda_s};
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == 4'h8) begin
            if (sh_reg[7:1] == SLAVE_ADDR) begin
              drv_next = 1'b1;
              rw_next  = sh_reg[0];
              st_next  = lamp_pkg::SER_AACK;
            end else begin
              st_next  = lamp_pkg::SER_IDLE;
            end
          end
        end
        lamp_pkg::SER_AACK: begin
          // End of address ack; read loads status
          if (scl_fall) begin
            cnt_next = 4'h0;
            if (rw_reg) begin
              tx_next  = stat_next;
              drv_next = ~stat_next[7];
              st_next  = lamp_pkg::SER_RDATA;
            end else begin
              drv_next = 1'b0;
              st_next  = lamp_pkg::SER_WDATA;
            end
          end
        end
        lamp_pkg::SER_WDATA: begin
          // Receive a data byte
          if (scl_rise) begin
            sh_next  = {sh_reg[6:0], sda_s};
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == 4'h8) begin
            drv_next  = 1'b1;
            pend_next = sh_reg;
            pv_next   = 1'b1;
            st_next   = lamp_pkg::SER_WACK;
          end
        end
        lamp_pkg::SER_WACK: begin
          // Further bytes replace the pending one
          if (scl_fall) begin
            drv_next = 1'b0;
            cnt_next = 4'h0;
            st_next  = lamp_pkg::SER_WDATA;
          end
        end
        lamp_pkg::SER_RDATA: begin
          // Send status, MSB first, changing on clock low
          if (scl_rise) begin
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (cnt_reg == 4'h8) begin
              drv_next = 1'b0;
              st_next  = lamp_pkg::SER_RACK;
            end else begin
              tx_next  = {tx_reg[6:0], 1'b1};
              drv_next = ~tx_reg[6];
            end
          end
        end
        lamp_pkg::SER_RACK: begin
          // Host nack ends the read; ack repeats the status
          if (scl_rise && sda_s) begin
            st_next = lamp_pkg::SER_IDLE;
          end else if (scl_fall) begin
            cnt_next = 4'h0;
            tx_next  = stat_next;
            drv_next = ~stat_next[7];
            st_next  = lamp_pkg::SER_RDATA;
          end
        end
        default: begin
          st_next  = lamp_pkg::SER_IDLE;
          drv_next = 1'b0;
        end
      endcase
    end
  end

  // Slave state registers; no reset of bank or run bits by the bus
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg   <= lamp_pkg::SER_IDLE;
      cnt_reg  <= 4'h0;
      sh_reg   <= 8'h00;
      tx_reg   <= 8'hff;
      drv_reg  <= 1'b0;
      rw_reg   <= 1'b0;
      pend_reg <= 8'h00;
      pv_reg   <= 1'b0;
    end else begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      sh_reg   <= sh_next;
      tx_reg   <= tx_next;
      drv_reg  <= drv_next;
      rw_reg   <= rw_next;
      pend_reg <= pend_next;
      pv_reg   <= pv_next;
    end
  end

  // Open-drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe  = drv_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Chop generator and power stage gating

  logic lamp_on;        // Inside the on interval

  chop_pwm #(
    .PERIOD (PERIOD)
  ) u_chop (
    .clk     (clk),
    .rst     (rst),
    .code    (cfg_sel[`CFG_CODE_MSB:0]),
    .lamp_on (lamp_on)
  );

  logic chop_next;      // Chop output level
  logic sw_next;        // Power switch allowed
  logic hiz_next;       // Compensation released
  logic chop_reg;
  logic sw_reg;
  logic hiz_reg;

  // Without the strap the lamp runs continuously and chop stays high
  always_comb begin
    if (strap_s) begin
      chop_next = lamp_on;
      hiz_next  = ~lamp_on;
    end else begin
      chop_next = 1'b1;
      hiz_next  = 1'b0;
    end
    sw_next = chop_next & ~shutdown & ~standby;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chop_reg <= 1'b0;
      sw_reg   <= 1'b0;
      hiz_reg  <= 1'b0;
    end else begin
      chop_reg <= chop_next;
      sw_reg   <= sw_next;
      hiz_reg  <= hiz_next;
    end
  end

  assign chop_out              = chop_reg;
  assign switch_enable         = sw_reg;
  assign compensation_node_hiz = hiz_reg;

endmodule
`default_nettype wire

/* File: bench/lamp_chop_duty_and_status_asserts.sv */
// Port-level checks for the lamp chop, status and serial block
`timescale 1ns/1ps
`default_nettype none
module lamp_chop_duty_and_status_asserts #(
  parameter int PERIOD = 1024
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       config_bank_select,
  input wire logic       chop_mode_strap,
  input wire logic       open_lamp_trip,
  input wire logic       chop_out,
  input wire logic       switch_enable,
  input wire logic       compensation_node_hiz,
  input wire logic       shutdown,
  input wire logic       standby,
  input wire logic [7:0] status_byte
);
  logic        rise;        // Chop output rising now
  logic        chop_d_reg;  // Chop output one cycle ago
  logic        chop_d_next;
  logic [10:0] gap_reg;     // Cycles since the last rise, saturating
  logic [10:0] gap_next;
  logic        valid_reg;   // Last rise was within one period
  logic        valid_next;
  logic        moved;       // Code or strap moved this cycle
  logic [4:0]  code_d_reg;  // Status code one cycle ago
  logic [4:0]  code_d_next;
  logic        strap_d_reg; // Strap pin one cycle ago
  logic        strap_d_next;
  logic [2:0]  calm_reg;    // Cycles since a move, saturating
  logic [2:0]  calm_next;

  ////////////////////////////////////////////////////////////////////////
  // Rise-to-rise counter; a gap past one period drops the check, since
  // codes zero and full scale have no rises at all. A code or strap move
  // can start an on interval mid-period, so it also drops the check
  always_comb begin
    chop_d_next  = chop_out;
    code_d_next  = status_byte[4:0];
    strap_d_next = chop_mode_strap;
    rise         = chop_out & ~chop_d_reg;
    moved        = (status_byte[4:0] != code_d_reg) | (chop_mode_strap != strap_d_reg);
    calm_next    = moved ? 3'h0 : ((calm_reg == 3'h7) ? calm_reg : calm_reg + 3'h1);
    gap_next     = rise ? 11'h000 : ((gap_reg == 11'h7ff) ? gap_reg : gap_reg + 11'h001);
    valid_next   = ~moved & ((rise & (calm_reg == 3'h7)) | (valid_reg & (gap_reg < 11'(PERIOD))));
  end

  // Registers only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chop_d_reg  <= 1'b0;
      gap_reg     <= 11'h000;
      valid_reg   <= 1'b0;
      code_d_reg  <= 5'h00;
      strap_d_reg <= 1'b0;
      calm_reg    <= 3'h0;
    end else begin
      chop_d_reg  <= chop_d_next;
      gap_reg     <= gap_next;
      valid_reg   <= valid_next;
      code_d_reg  <= code_d_next;
      strap_d_reg <= strap_d_next;
      calm_reg    <= calm_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_sda_value_low: assert property (sda_out == 1'b0) else $error("data value not low");
  chk_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("data moved, clock high");
  chk_switch_on_time: assert property (switch_enable |-> chop_out) else $error("switch on in off time");
  chk_hiz_off_time: assert property (compensation_node_hiz |-> !chop_out) else $error("hiz in on time");
  chk_switch_run: assert property (switch_enable |-> !$past(shutdown) && !$past(standby))
    else $error("switch on while stopped");
  chk_fill_ones: assert property (status_byte[6:5] == 2'h3) else $error("unused status bits");
  chk_ok_rearm: assert property ((shutdown || standby)[*2] |=> status_byte[7]) else $error("flag not rearmed");
  chk_ok_latched: assert property ($rose(status_byte[7]) |-> $past(shutdown || standby) ||
    $past(shutdown || standby, 2)) else $error("flag rose unasked");
  chk_full_scale: assert property ((status_byte[4:0] == 5'h1f)[*2] |-> chop_out) else $error("full not on");
  chk_zero_code: assert property ((status_byte[4:0] == 5'h00 && chop_mode_strap)[*8] |-> !chop_out)
    else $error("zero code lit");
  chk_strap_low: assert property ((!chop_mode_strap)[*8] |-> chop_out) else $error("chopping, strap low");
  chk_chop_period: assert property (rise && valid_reg |-> gap_reg == 11'(PERIOD - 1))
    else $error("chop period wrong");
endmodule

bind lamp_chop_duty_and_status lamp_chop_duty_and_status_asserts #(.PERIOD(PERIOD))
  i_lamp_chop_duty_and_status_asserts (
  .clk(clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .config_bank_select(config_bank_select), .chop_mode_strap(chop_mode_strap), .open_lamp_trip(open_lamp_trip),
  .chop_out(chop_out), .switch_enable(switch_enable), .compensation_node_hiz(compensation_node_hiz),
  .shutdown(shutdown), .standby(standby), .status_byte(status_byte));
`default_nettype wire

/* File: bench/smbus_host_model.sv */
// Serial bus host: drives the clock pin and pulls the data pin low
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
  input  wire logic clk,
  input  wire logic sda_line,
  output var logic  scl,
  output var logic  sda_low
);
  // Idle bus, both lines left to the pull-ups
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // Pins move only at falling clock edges
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Start or repeated start; the lead-in keeps data off the clock fall
  task automatic bus_start();
    hold(4);
    sda_low = 1'b0;
    hold(8);
    scl = 1'b1;
    hold(16);
    sda_low = 1'b1;
    hold(16);
    scl = 1'b0;
  endtask

  // Stop: data rises while the clock is high
  task automatic bus_stop();
    hold(4);
    sda_low = 1'b1;
    hold(8);
    scl = 1'b1;
    hold(16);
    sda_low = 1'b0;
    hold(16);
  endtask

  // One bit: set well after the fall, read late in the high phase,
  // leaving room for the device's pin filter
  task automatic bit_io(input logic b, output logic r);
    hold(4);
    sda_low = ~b;
    hold(12);
    scl = 1'b1;
    hold(16);
    r = sda_line;
    scl = 1'b0;
  endtask

  // Byte MSB first plus ninth bit; sending ones releases the line to read
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(last, ack);
  endtask
endmodule
`default_nettype wire

/* File: bench/test_lamp_chop_duty_and_status.sv */
// Self-checking bench for the lamp chop, status and serial block
`timescale 1ns/1ps
`default_nettype none
`include "lamp_cfg.svh"
module test_lamp_chop_duty_and_status;
  logic       clk = 1'b0;  // Switching clock, 40 ns
  logic       rst;
  logic       scl;         // Host clock pin
  logic       sda_low;     // Host pulls data low
  logic       sda_line;    // Resolved data wire, pulled up
  logic       bank_sel;
  logic       strap;
  logic       trip;
  logic       sda_out;
  logic       sda_oe;
  logic       chop_out;
  logic       switch_enable;
  logic       hiz;
  logic       shutdown;
  logic       standby;
  logic [7:0] status_byte;
  int         n_mismatch = 0;
  int         checks = 0;
  logic [4:0] codes [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h10, 5'h1e, 5'h1f};

  always #20 clk = ~clk;
  // Open drain wire: low when either side pulls
  assign sda_line = ~(sda_low | (sda_oe & ~sda_out));

  lamp_chop_duty_and_status #(.SLAVE_ADDR(`SLAVE_ADDR), .PERIOD(`CHOP_PERIOD)) i_lamp_chop_duty_and_status (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .config_bank_select(bank_sel), .chop_mode_strap(strap), .open_lamp_trip(trip), .chop_out(chop_out),
    .switch_enable(switch_enable), .compensation_node_hiz(hiz), .shutdown(shutdown), .standby(standby),
    .status_byte(status_byte));

  smbus_host_model i_smbus_host_model (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

  ////////////////////////////////////////////////////////////////////////
  // Compare tasks
  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t bit got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t byte got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_cnt(input int got, input int exp);
    checks++;
    if (got != exp) begin
      n_mismatch++;
      $display("[ERR] %0t count got %0d exp %0d", $time, got, exp);
    end
  endtask

  // Send-byte write; a foreign address must go unanswered
  task automatic write_cfg(input logic [7:0] b, input logic [6:0] a);
    logic [7:0] rx;
    logic       ack;
    i_smbus_host_model.bus_start();
    i_smbus_host_model.xfer({a, 1'b0}, 1'b1, rx, ack);
    cmp_bit(ack, a != `SLAVE_ADDR);
    if (ack === 1'b0) begin
      i_smbus_host_model.xfer(b, 1'b1, rx, ack);
      cmp_bit(ack, 1'b0);
    end
    i_smbus_host_model.bus_stop();
  endtask

  // Read-byte: command, repeated start, host ack repeats the byte, then nack
  task automatic read_status(input logic [7:0] exp);
    logic [7:0] rx;
    logic       ack;
    i_smbus_host_model.bus_start();
    i_smbus_host_model.xfer({`SLAVE_ADDR, 1'b0}, 1'b1, rx, ack);
    i_smbus_host_model.xfer(8'h00, 1'b1, rx, ack);
    i_smbus_host_model.bus_start();
    i_smbus_host_model.xfer({`SLAVE_ADDR, 1'b1}, 1'b1, rx, ack);
    cmp_bit(ack, 1'b0);
    i_smbus_host_model.xfer(8'hff, 1'b0, rx, ack);
    cmp_byte(rx, exp);
    i_smbus_host_model.xfer(8'hff, 1'b1, rx, ack);
    cmp_byte(rx, exp);
    i_smbus_host_model.bus_stop();
  endtask

  // On-time within the period for a code; codes one to three share a floor
  function automatic int thr(input int c);
    if (c == 0) return 0;
    if (c < 4) return 99;
    if (c == 31) return 1024;
    return c * 33;
  endfunction

  // One full period, after the new code has settled for a whole period
  task automatic measure(input int exp_on);
    int on = 0;
    int sw = 0;
    int hz = 0;
    repeat (1100) @(negedge clk);
    repeat (1024) @(negedge clk) begin
      on += int'(chop_out === 1'b1);
      sw += int'(switch_enable === 1'b1);
      hz += int'(hiz === 1'b1);
    end
    cmp_cnt(on, exp_on);
    cmp_cnt(sw, exp_on);
    cmp_cnt(hz, strap ? 1024 - exp_on : 0);
  endtask

  // Verdict, reached from the main sequence or the watchdog
  task automatic end_sim();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1;
    bank_sel = 1'b0;
    strap = 1'b0;
    trip = 1'b0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    cmp_byte(status_byte, 8'hf0);
    cmp_bit(shutdown, 1'b0);
    write_cfg(8'h00, `SLAVE_ADDR ^ 7'h01);
    write_cfg(8'h6a, `SLAVE_ADDR);
    write_cfg(8'hf5, `SLAVE_ADDR);
    read_status(8'hea);
    bank_sel = 1'b1;
    repeat (10) @(negedge clk);
    read_status(8'hf5);
    write_cfg(8'hb5, `SLAVE_ADDR);
    cmp_bit(shutdown, 1'b1);
    read_status(8'hf5);
    bank_sel = 1'b0;
    repeat (10) @(negedge clk);
    cmp_bit(shutdown, 1'b0);
    bank_sel = 1'b1;
    repeat (10) @(negedge clk);
    write_cfg(8'hf5, `SLAVE_ADDR);
    cmp_bit(shutdown, 1'b0);
    trip = 1'b1;
    repeat (10) @(negedge clk);
    trip = 1'b0;
    repeat (10) @(negedge clk);
    cmp_byte(status_byte, 8'h75);
    write_cfg(8'hd5, `SLAVE_ADDR);
    cmp_bit(standby, 1'b1);
    write_cfg(8'hf5, `SLAVE_ADDR);
    cmp_byte(status_byte, 8'hf5);
    bank_sel = 1'b0;
    write_cfg(8'h60, `SLAVE_ADDR);
    measure(1024);
    strap = 1'b1;
    foreach (codes[i]) begin
      write_cfg({3'b011, codes[i]}, `SLAVE_ADDR);
      measure(thr(int'(codes[i])));
    end
    end_sim();
  end

  // Watchdog against a hung sequence
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end
endmodule
`default_nettype wire
